/* File: include/dmb_cfg.svh */
// Purpose: constants for the data memory banking block
// Assumes: 8-bit data, two banks of 256 locations
// Notes:   offsets are data memory addresses
`ifndef DMB_CFG_SVH
`define DMB_CFG_SVH

// ==========================================
// Register offsets
`define DMB_OFS_INDIRECT_PORT_0    8'h00
`define DMB_OFS_MEMORY_POINTER_0   8'h01
`define DMB_OFS_INDIRECT_PORT_1    8'h02
`define DMB_OFS_MEMORY_POINTER_1   8'h03
`define DMB_OFS_BANK_SELECT        8'h04
`define DMB_OFS_ACCUMULATOR_REG    8'h05
`define DMB_OFS_PROGRAM_COUNTER_LOW 8'h06

// ==========================================
// Fields and reset values
`define DMB_BANK_BIT_POS           0
`define DMB_BANK_SELECT_RESET      1'h0
`define DMB_BANK_SELECT_MASK       8'h01
`define DMB_ZERO_BYTE              8'h00

// ==========================================
// Timing
`define DMB_PCL_DUMMY_CYCLES       1

`endif

/* File: include/dmb_pkg.sv */
// Purpose: types for the data memory banking block
// Assumes: nothing
// Notes:   constants live in dmb_cfg.svh
package dmb_pkg;
    typedef enum logic [1:0] {
        DMB_ST_IDLE  = 2'b00,
        DMB_ST_DUMMY = 2'b01
    } dmb_state_t;

    typedef enum logic [1:0] {
        DMB_ALU_PASS = 2'b00,
        DMB_ALU_ADD  = 2'b01,
        DMB_ALU_SUB  = 2'b10,
        DMB_ALU_INC  = 2'b11
    } dmb_alu_t;
endpackage

/* File: logic/dmb_ram.sv */
// Purpose: banked general data memory, 512 x 8
// Assumes: one port, write and read in the same cycle
// Notes:   read data is registered
`timescale 1ns/1ps
module dmb_ram (
    // Clock
    input  wire logic       ref_clk,
    // Access
    input  wire logic [8:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [0:511];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // dmb_ram

/* File: logic/dmb_core.sv */
// Purpose: indirect addressing, bank select, accumulator and PC low byte
// Assumes: core presents one data access per cycle, all inputs but rst synchronous
// Notes:   read data appears one cycle after the request
`timescale 1ns/1ps
`include "dmb_cfg.svh"

module dmb_core (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             wdt_pd_reset,
    // Data access from the core
    input  wire logic             acc_valid,
    input  wire logic             acc_write,
    input  wire logic [7:0]       acc_addr,
    input  wire logic [7:0]       acc_wdata,
    // ALU request from the core
    input  wire logic             alu_valid,
    input  wire dmb_pkg::dmb_alu_t alu_op,
    input  wire logic [7:0]       alu_operand,
    // Program counter
    input  wire logic [12:0]      pc_current,
    // Results
    output logic      [7:0]       rd_data,
    output logic                  rd_valid,
    output logic      [7:0]       accumulator_reg,
    output logic      [7:0]       memory_pointer_0,
    output logic      [7:0]       memory_pointer_1,
    output logic                  data_bank_bit,
    output logic                  pc_load,
    output logic      [12:0]      pc_target,
    output logic                  dummy_cycle
);
    // ==========================================
    // State
    logic [7:0]          mp0_reg, mp0_next;
    logic [7:0]          mp1_reg, mp1_next;
    logic                bank_reg, bank_next;
    logic [7:0]          acc_reg, acc_next;
    logic [7:0]          rsel_reg, rsel_next;
    logic                rram_reg, rram_next;
    logic                rval_reg, rval_next;
    logic                pcl_reg, pcl_next;
    logic [12:0]         pct_reg, pct_next;
    dmb_pkg::dmb_state_t st_reg, st_next;
    logic                wdt_pd_seen;
    logic                dum_reg;

    // Decoded access
    logic [7:0]          tgt_addr;
    logic                tgt_bank;
    logic                via_port;
    logic                slot_free;
    logic                wr_go;
    logic                rd_go;

    logic [8:0] ram_addr;
    logic       ram_we;
    logic [7:0] ram_rdata;

    // Effective address for a port: bank bit over pointer on port 1, bank 0 over pointer on port 0
    function automatic logic [8:0] eff_addr(input logic bank, input logic [7:0] ptr);
        eff_addr = {bank, ptr};
    endfunction

    function automatic logic is_port(input logic [7:0] a);
        is_port = (a == `DMB_OFS_INDIRECT_PORT_0) || (a == `DMB_OFS_INDIRECT_PORT_1);
    endfunction

    // Locations 00H..06H are shared by both banks
    function automatic logic is_special(input logic [7:0] a);
        is_special = (a <= `DMB_OFS_PROGRAM_COUNTER_LOW);
    endfunction

    function automatic logic [7:0] alu_result(input dmb_pkg::dmb_alu_t op,
                                              input logic [7:0]        a,
                                              input logic [7:0]        b);
        unique case (op)
            dmb_pkg::DMB_ALU_PASS: alu_result = b;
            dmb_pkg::DMB_ALU_ADD:  alu_result = 8'(a + b);
            dmb_pkg::DMB_ALU_SUB:  alu_result = 8'(a - b);
            dmb_pkg::DMB_ALU_INC:  alu_result = 8'(b + 8'h01);
        endcase
    endfunction

    dmb_ram u_ram (
        .ref_clk (ref_clk),
        .addr    (ram_addr),
        .wr_en   (ram_we),
        .wr_data (acc_wdata),
        .rd_data (ram_rdata)
    );

    // ==========================================
    // Access decode
    // Special registers sit in the shared area, so a pointer reaches
    // them whatever bank it selects
    always_comb begin
        tgt_addr = acc_addr;
        tgt_bank = 1'b0;
        via_port = 1'b0;
        if (acc_addr == `DMB_OFS_INDIRECT_PORT_0) begin
            tgt_addr = mp0_reg;
            via_port = 1'b1;
            tgt_bank = 1'b0;
        end else if (acc_addr == `DMB_OFS_INDIRECT_PORT_1) begin
            tgt_addr = mp1_reg;
            via_port = 1'b1;
            tgt_bank = bank_reg;
        end
        // Dummy slot after a jump swallows whatever the core presents
        slot_free = (st_reg == dmb_pkg::DMB_ST_IDLE);
        // A port reached through a pointer holds no storage
        wr_go     = acc_valid && acc_write && slot_free
                    && !(via_port && is_port(tgt_addr));
        rd_go     = acc_valid && !acc_write && slot_free;
        ram_addr  = eff_addr(tgt_bank, tgt_addr);
        ram_we    = wr_go && !is_special(tgt_addr);
    end

    // ==========================================
    // Memory pointers
    always_comb begin
        mp0_next = mp0_reg;
        mp1_next = mp1_reg;
        if (wr_go && tgt_addr == `DMB_OFS_MEMORY_POINTER_0) begin
            mp0_next = acc_wdata;
        end
        if (wr_go && tgt_addr == `DMB_OFS_MEMORY_POINTER_1) begin
            mp1_next = acc_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mp0_reg <= `DMB_ZERO_BYTE;
            mp1_reg <= `DMB_ZERO_BYTE;
        end else begin
            mp0_reg <= mp0_next;
            mp1_reg <= mp1_next;
        end
    end

    // ==========================================
    // Bank select
    // Reset is sampled here; an asynchronous clear could not spare the
    // bank on a watchdog reset taken in power down
    always_comb begin
        bank_next = bank_reg;
        if (wr_go && tgt_addr == `DMB_OFS_BANK_SELECT) begin
            bank_next = acc_wdata[`DMB_BANK_BIT_POS];
        end
        if (rst) begin
            bank_next = wdt_pd_reset ? bank_reg : `DMB_BANK_SELECT_RESET;
        end else if (wdt_pd_seen) begin
            bank_next = bank_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        bank_reg <= bank_next;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdt_pd_seen <= 1'b0;
        end else begin
            wdt_pd_seen <= wdt_pd_reset;
        end
    end

    // ==========================================
    // Accumulator
    // An ALU result wins over a data write in the same slot
    always_comb begin
        acc_next = acc_reg;
        if (wr_go && tgt_addr == `DMB_OFS_ACCUMULATOR_REG) begin
            acc_next = acc_wdata;
        end
        if (alu_valid && slot_free) begin
            acc_next = alu_result(alu_op, acc_reg, alu_operand);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= `DMB_ZERO_BYTE;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // ==========================================
    // Read path
    always_comb begin
        rsel_next = `DMB_ZERO_BYTE;
        rram_next = 1'b0;
        rval_next = rd_go;
        if (rd_go && !(via_port && is_port(tgt_addr))) begin
            unique case (tgt_addr)
                `DMB_OFS_MEMORY_POINTER_0:    rsel_next = mp0_reg;
                `DMB_OFS_MEMORY_POINTER_1:    rsel_next = mp1_reg;
                `DMB_OFS_BANK_SELECT:
                    rsel_next = {7'h00, bank_reg} & `DMB_BANK_SELECT_MASK;
                `DMB_OFS_ACCUMULATOR_REG:     rsel_next = acc_reg;
                `DMB_OFS_PROGRAM_COUNTER_LOW: rsel_next = pc_current[7:0];
                default:                      rram_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsel_reg <= `DMB_ZERO_BYTE;
            rram_reg <= 1'b0;
            rval_reg <= 1'b0;
        end else begin
            rsel_reg <= rsel_next;
            rram_reg <= rram_next;
            rval_reg <= rval_next;
        end
    end

    // ==========================================
    // Program counter low byte
    always_comb begin
        pcl_next = 1'b0;
        pct_next = pct_reg;
        st_next  = dmb_pkg::DMB_ST_IDLE;
        if (wr_go && tgt_addr == `DMB_OFS_PROGRAM_COUNTER_LOW) begin
            pcl_next = 1'b1;
            pct_next = {pc_current[12:8], acc_wdata};
            st_next  = dmb_pkg::DMB_ST_DUMMY;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pcl_reg <= 1'b0;
            pct_reg <= 13'h0000;
            st_reg  <= dmb_pkg::DMB_ST_IDLE;
            dum_reg <= 1'b0;
        end else begin
            pcl_reg <= pcl_next;
            pct_reg <= pct_next;
            st_reg  <= st_next;
            dum_reg <= (st_next == dmb_pkg::DMB_ST_DUMMY);
        end
    end

    // ==========================================
    // Outputs
    // Read data picks between the memory's own register and the special
    // register byte; an extra stage would cost a cycle of read latency
    always_comb begin
        rd_data          = rram_reg ? ram_rdata : rsel_reg;
        rd_valid         = rval_reg;
        accumulator_reg  = acc_reg;
        memory_pointer_0 = mp0_reg;
        memory_pointer_1 = mp1_reg;
        data_bank_bit    = bank_reg;
        pc_load          = pcl_reg;
        pc_target        = pct_reg;
        dummy_cycle      = dum_reg;
    end
endmodule // dmb_core

/* File: verif/dmb_core_assertions.sv */
// Purpose: port checks for dmb_core
// Assumes: one clock, rst async active high
// Notes:   bound into every dmb_core
`timescale 1ns/1ps
module dmb_core_assertions (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Access
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [7:0]  acc_addr,
    input wire logic [7:0]  acc_wdata,
    input wire logic [12:0] pc_current,
    // Results
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid,
    input wire logic [7:0]  accumulator_reg,
    input wire logic [7:0]  memory_pointer_0,
    input wire logic        data_bank_bit,
    input wire logic        pc_load,
    input wire logic [12:0] pc_target,
    input wire logic        dummy_cycle
);
    logic wr_ok;
    logic rd_ok;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    assign wr_ok = acc_valid && acc_write && !dummy_cycle;
    assign rd_ok = acc_valid && !acc_write && !dummy_cycle;
    // ========================================
    // Program counter low byte
    pcl_jump_a: assert property (wr_ok && acc_addr == 8'h06 |=> pc_load
        && pc_target == {$past(pc_current[12:8]), $past(acc_wdata)}) else $error("bad pc jump");
    dummy_one_a: assert property (pc_load |-> dummy_cycle ##1 !dummy_cycle)
        else $error("dummy cycle length wrong");
    dummy_drop_a: assert property (dummy_cycle |=> !pc_load && !rd_valid)
        else $error("access taken in dummy cycle");
    // ========================================
    // Registers and reads
    bank_write_a: assert property (wr_ok && acc_addr == 8'h04 |=>
        data_bank_bit == $past(acc_wdata[0])) else $error("bank bit not written");
    bank_hold_a: assert property (!(wr_ok && acc_addr == 8'h04) |=> $stable(data_bank_bit))
        else $error("bank bit changed");
    mp0_write_a: assert property (wr_ok && acc_addr == 8'h01 |=>
        memory_pointer_0 == $past(acc_wdata)) else $error("pointer 0 not written");
    acc_write_a: assert property (wr_ok && acc_addr == 8'h05 |=>
        accumulator_reg == $past(acc_wdata)) else $error("accumulator not written");
    rd_answer_a: assert property (rd_ok |=> rd_valid) else $error("read not answered");
    port_zero_a: assert property (rd_ok && acc_addr == 8'h00 && (memory_pointer_0 == 8'h00
        || memory_pointer_0 == 8'h02) |=> rd_data == 8'h00) else $error("port read not zero");
endmodule // dmb_core_assertions

bind dmb_core dmb_core_assertions dmb_core_assertions_inst (.ref_clk, .rst, .acc_valid,
    .acc_write, .acc_addr, .acc_wdata, .pc_current, .rd_data, .rd_valid, .accumulator_reg,
    .memory_pointer_0, .data_bank_bit, .pc_load, .pc_target, .dummy_cycle);

/* File: verif/dmb_cpu_model.sv */
// Purpose: instruction core side issuing data accesses
// Assumes: answer within three cycles
// Notes:   one idle cycle between accesses
`timescale 1ns/1ps
module dmb_cpu_model (
    // Clock
    input wire logic       ref_clk,
    // Access
    output logic           acc_valid = 1'b0,
    output logic           acc_write = 1'b0,
    output logic     [7:0] acc_addr = 8'h00,
    output logic     [7:0] acc_wdata = 8'h00,
    // Answer
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data
);
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge ref_clk);
        acc_valid <= 1'b0;
        // Released lines flip so a stale value cannot pass for live
        acc_addr <= ~a;
        acc_wdata <= ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] q);
        q = 'x;
        put(1'b0, a, 8'hC3);
        repeat (3) begin
            #1;
            if (rd_valid === 1'b1) begin
                q = rd_data;
                return;
            end
            @(posedge ref_clk);
        end
    endtask
endmodule // dmb_cpu_model

/* File: verif/tb.sv */
// Purpose: self-checking bench for dmb_core
// Assumes: reads answer within three cycles
// Notes:   stops early on watchdog
`timescale 1ns/1ps
module tb;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic               wdt_pd_reset = 1'b0;
    logic               acc_valid, acc_write, rd_valid, data_bank_bit, pc_load, dummy_cycle;
    logic [7:0]         acc_addr, acc_wdata, rd_data, accumulator_reg, q;
    logic [7:0]         memory_pointer_0, memory_pointer_1, alu_operand = 8'h00;
    logic               alu_valid = 1'b0;
    dmb_pkg::dmb_alu_t  alu_op = dmb_pkg::DMB_ALU_PASS;
    logic [12:0]        pc_current = 13'h1A37;
    logic [12:0]        pc_target;
    int                 n_errors = 0;
    int                 cmp_count = 0;
    always #50 ref_clk = ~ref_clk;
    dmb_cpu_model dmb_cpu_model_inst (.ref_clk, .acc_valid, .acc_write, .acc_addr,
        .acc_wdata, .rd_valid, .rd_data);
    dmb_core dmb_core_inst (.ref_clk, .rst, .wdt_pd_reset, .acc_valid, .acc_write, .acc_addr,
        .acc_wdata, .alu_valid, .alu_op, .alu_operand, .pc_current, .rd_data, .rd_valid,
        .accumulator_reg, .memory_pointer_0, .memory_pointer_1, .data_bank_bit, .pc_load,
        .pc_target, .dummy_cycle);
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reset_dev(input logic wdt);
        @(posedge ref_clk);
        rst <= 1'b1;
        wdt_pd_reset <= wdt;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        wdt_pd_reset <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        dmb_cpu_model_inst.get(a, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dmb_cpu_model_inst.put(1'b1, a, d);
    endtask
    task automatic t_bank();
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h01);
        chk(data_bank_bit, 1'b1);
        wr(8'h04, 8'hFE);
        rd(8'h04, 8'h00);
    endtask
    task automatic t_ind();
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h60);
        wr(8'h02, 8'h5A);
        wr(8'h04, 8'h00);
        wr(8'h60, 8'hA5);
        wr(8'h01, 8'h60);
        rd(8'h00, 8'hA5);
        rd(8'h02, 8'hA5);
        wr(8'h04, 8'h01);
        rd(8'h02, 8'h5A);
        rd(8'h60, 8'hA5);
        rd(8'h00, 8'hA5);
        chk(memory_pointer_1, 8'h60);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h33);
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h5A);
        rd(8'h01, 8'h02);
        wr(8'h03, 8'h00);
        rd(8'h02, 8'h00);
    endtask
    task automatic t_alu();
        logic [7:0] opnd [4] = '{8'h12, 8'h05, 8'h07, 8'h3F};
        logic [7:0] res [4] = '{8'h12, 8'h17, 8'h10, 8'h40};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            alu_valid <= 1'b1;
            alu_op <= dmb_pkg::dmb_alu_t'(i);
            alu_operand <= opnd[i];
            @(posedge ref_clk);
            alu_valid <= 1'b0;
            #1 chk(accumulator_reg, res[i]);
        end
        rd(8'h05, 8'h40);
    endtask
    task automatic t_pcl();
        @(posedge ref_clk);
        dmb_cpu_model_inst.acc_valid <= 1'b1;
        dmb_cpu_model_inst.acc_write <= 1'b1;
        dmb_cpu_model_inst.acc_addr <= 8'h06;
        dmb_cpu_model_inst.acc_wdata <= 8'h5C;
        @(posedge ref_clk);
        // Second write lands in the dummy cycle and must be dropped
        dmb_cpu_model_inst.acc_addr <= 8'h01;
        dmb_cpu_model_inst.acc_wdata <= 8'h99;
        #1 chk(pc_target, 13'h1A5C);
        chk(pc_load, 1'b1);
        chk(dummy_cycle, 1'b1);
        @(posedge ref_clk);
        dmb_cpu_model_inst.acc_valid <= 1'b0;
        #1 chk(memory_pointer_0, 8'h02);
        chk(dummy_cycle, 1'b0);
        chk(pc_load, 1'b0);
    endtask
    task automatic t_wdt();
        wr(8'h04, 8'h01);
        reset_dev(1'b1);
        rd(8'h04, 8'h01);
        reset_dev(1'b0);
        rd(8'h04, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h04, 8'h00);
        t_bank();
        t_ind();
        t_alu();
        t_pcl();
        t_wdt();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end
endmodule // tb
